//--- dio_pkg.sv
// Package with register map, field layout and carrier types for the digital I/O block
package dio_pkg;

  localparam int GROUP_W = 8;
  localparam int N_GROUPS = 3;
  localparam int DED_W = 16;

  // Register byte offsets
  localparam logic [7:0] OFS_ENABLE  = 8'h00;
  localparam logic [7:0] OFS_DIR     = 8'h04;
  localparam logic [7:0] OFS_GROUP0  = 8'h08;
  localparam logic [7:0] OFS_GROUP1  = 8'h0c;
  localparam logic [7:0] OFS_GROUP2  = 8'h10;
  localparam logic [7:0] OFS_DED_IN  = 8'h14;
  localparam logic [7:0] OFS_DED_OUT = 8'h18;
  localparam int ADDR_W = 8;

  // Field positions and reset values
  localparam int ENABLE_BIT = 0;
  localparam logic [2:0] DIR_RESET = 3'h0;
  localparam logic ENABLE_RESET = 1'b0;
  localparam logic [15:0] DED_OUT_RESET = 16'h0000;

  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic HRESP_OKAY = 1'b0;

  // Pins of the bidirectional port
  typedef struct packed {
    logic [N_GROUPS*GROUP_W-1:0] dout;
    logic [N_GROUPS*GROUP_W-1:0] oe;
  } dio_pins_t;

  // Latched AHB address phase
  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
  } dio_aphase_t;

endpackage

//--- dio_group.sv
// One 8-bit group of the bidirectional port: latch, direction gating and readback
`timescale 1ns/1ns
module dio_group
  import dio_pkg::*;
#(
  parameter int W = GROUP_W
)
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         enable,
  input  wire logic         is_output,
  input  wire logic         wr_stb,
  input  wire logic [W-1:0] wr_data,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_out,
  output logic      [W-1:0] pin_oe,
  output logic      [W-1:0] rd_data
);

  logic [W-1:0] latch_r;
  logic [W-1:0] sample_r;

  // Latch written regardless of direction, no reset value
  always_ff @(posedge clk)
  begin
    if (wr_stb)
      latch_r <= wr_data;
  end

  // Input sampling only while operations are enabled
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      sample_r <= '0;
    else if (enable && !is_output)
      sample_r <= pin_in;
  end

  assign pin_out = latch_r;
  assign pin_oe  = (enable && is_output) ? {W{1'b1}} : {W{1'b0}};

  always_comb
  begin
    if (is_output)
      rd_data = latch_r;
    else
      rd_data = sample_r;
  end

endmodule

//--- dio_port_ctrl.sv
// Digital I/O port controller with AHB-Lite register slave
//
// Operation
// - I/O disabled until host sets enable
// - Groups start as inputs, drivers off
// - Output latches undefined after power-on
// - Enable low disables bidirectional port
// - Enable high allows ops per direction
// - Input group reads sampled pin levels
// - Output group reads its latch value
// - Write to input group updates latch only
// - Switch to output drives latch immediately
// - Dedicated input gated by enable
// - Dedicated output gated by enable
// - Dedicated output starts disabled
// - Dedicated output latches reset low
// - Three 8-bit groups, separate lines
// - Sixteen dedicated input lines readable
// - Sixteen latched dedicated output lines
// - Each group direction set independently
// - Reset returns groups to input
`timescale 1ns/1ns
module dio_port_ctrl
  import dio_pkg::*;
#(
  parameter bit HAS_DED = 1'b1
)
(
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic      [31:0]                 hrdata,
  output logic                             hreadyout,
  output logic                             hresp,
  input  wire logic [N_GROUPS*GROUP_W-1:0] group_line_in,
  output dio_pkg::dio_pins_t               group_pins,
  input  wire logic [DED_W-1:0]            dedicated_input_line,
  output logic      [DED_W-1:0]            dedicated_output_line,
  output logic      [DED_W-1:0]            dedicated_output_oe
);
  import dio_pkg::*;

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  dio_aphase_t  aph_r;
  logic         enable_r;
  logic [2:0]   dir_r;
  logic [15:0]  ded_out_r;
  logic [15:0]  ded_in_r;
  logic [N_GROUPS*GROUP_W-1:0] grp_rd;
  logic [N_GROUPS-1:0]         grp_wr;
  logic         wr_act;
  logic         addr_phase;

  assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  assign hreadyout  = 1'b1;
  assign hresp      = HRESP_OKAY;
  assign wr_act     = aph_r.valid && aph_r.write;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      aph_r <= '0;
    else if (hready)
    begin
      aph_r.valid <= addr_phase;
      aph_r.write <= hwrite;
      aph_r.addr  <= haddr[ADDR_W-1:0];
    end
  end

  function automatic logic hit(input dio_aphase_t a, input logic [ADDR_W-1:0] ofs);
    hit = a.valid && (a.addr == ofs);
  endfunction

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      enable_r <= ENABLE_RESET;
    else if (wr_act && hit(aph_r, OFS_ENABLE))
      enable_r <= hwdata[ENABLE_BIT];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      dir_r <= DIR_RESET;
    else if (wr_act && hit(aph_r, OFS_DIR))
      dir_r <= hwdata[N_GROUPS-1:0];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ded_out_r <= DED_OUT_RESET;
    else if (wr_act && hit(aph_r, OFS_DED_OUT) && HAS_DED)
      ded_out_r <= hwdata[DED_W-1:0];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ded_in_r <= '0;
    else if (enable_r && HAS_DED)
      ded_in_r <= dedicated_input_line;
  end

  // ---------------------------------------------------------------
  // Bidirectional groups
  // ---------------------------------------------------------------
  assign grp_wr[0] = wr_act && hit(aph_r, OFS_GROUP0);
  assign grp_wr[1] = wr_act && hit(aph_r, OFS_GROUP1);
  assign grp_wr[2] = wr_act && hit(aph_r, OFS_GROUP2);

  for (genvar g = 0; g < N_GROUPS; g++)
  begin : g_grp
    dio_group #(.W(GROUP_W)) u_grp (
      .clk       (clk),
      .rst_n     (rst_n),
      .enable    (enable_r),
      .is_output (dir_r[g]),
      .wr_stb    (grp_wr[g]),
      .wr_data   (hwdata[GROUP_W-1:0]),
      .pin_in    (group_line_in[g*GROUP_W +: GROUP_W]),
      .pin_out   (group_pins.dout[g*GROUP_W +: GROUP_W]),
      .pin_oe    (group_pins.oe[g*GROUP_W +: GROUP_W]),
      .rd_data   (grp_rd[g*GROUP_W +: GROUP_W])
    );
  end

  // ---------------------------------------------------------------
  // Dedicated output pins
  // ---------------------------------------------------------------
  assign dedicated_output_line = ded_out_r;
  assign dedicated_output_oe   = (enable_r && HAS_DED) ? {DED_W{1'b1}} : {DED_W{1'b0}};

  // ---------------------------------------------------------------
  // Read mux, data phase
  // ---------------------------------------------------------------
  always_comb
  begin
    hrdata = 32'h0000_0000;
    if (aph_r.valid && !aph_r.write)
    begin
      case (aph_r.addr)
        OFS_ENABLE:  hrdata[ENABLE_BIT] = enable_r;
        OFS_DIR:     hrdata[N_GROUPS-1:0] = dir_r;
        OFS_GROUP0:  hrdata[GROUP_W-1:0] = grp_rd[0 +: GROUP_W];
        OFS_GROUP1:  hrdata[GROUP_W-1:0] = grp_rd[GROUP_W +: GROUP_W];
        OFS_GROUP2:  hrdata[GROUP_W-1:0] = grp_rd[2*GROUP_W +: GROUP_W];
        OFS_DED_IN:  hrdata[DED_W-1:0] = HAS_DED ? ded_in_r : '0;
        OFS_DED_OUT: hrdata[DED_W-1:0] = HAS_DED ? ded_out_r : '0;
        default:     hrdata = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_disable_oe: assert property (@(posedge clk) disable iff (!rst_n)
    !enable_r |-> (group_pins.oe == '0 && dedicated_output_oe == '0))
    else $error("drivers on while disabled");

  a_dir_oe: assert property (@(posedge clk) disable iff (!rst_n)
    enable_r |-> group_pins.oe[GROUP_W] == dir_r[1])
    else $error("group1 oe mismatch");

  a_reset_dir: assert property (@(posedge clk)
    !rst_n |=> (dir_r == DIR_RESET && !enable_r && ded_out_r == DED_OUT_RESET))
    else $error("reset state wrong");

  a_dir_write: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_act && hit(aph_r, OFS_DIR)) |=> dir_r == $past(hwdata[N_GROUPS-1:0]))
    else $error("direction not stored");

  a_ded_write: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_act && hit(aph_r, OFS_DED_OUT)) |=> dedicated_output_line == $past(hwdata[DED_W-1:0]))
    else $error("dedicated out not stored");

  a_in_write: assert property (@(posedge clk) disable iff (!rst_n)
    (grp_wr[0] && !dir_r[0]) |=> group_pins.oe[GROUP_W-1:0] == '0)
    else $error("input group driven after write");

  a_switch_out: assert property (@(posedge clk) disable iff (!rst_n)
    (enable_r && $rose(dir_r[2])) |-> group_pins.oe[3*GROUP_W-1] ##0
      group_pins.dout[2*GROUP_W +: GROUP_W] == grp_rd[2*GROUP_W +: GROUP_W])
    else $error("group2 not driving latch");

  a_ded_en: assert property (@(posedge clk) disable iff (!rst_n)
    (enable_r && HAS_DED) |-> dedicated_output_oe == {DED_W{1'b1}})
    else $error("dedicated out not enabled");

  a_ded_in_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (!enable_r && $past(!enable_r)) |-> $stable(ded_in_r))
    else $error("dedicated in sampled while disabled");

  // Per-group driver enables follow their own direction bit
  a_g0_oe: assert property (@(posedge clk) disable iff (!rst_n)
    enable_r |-> group_pins.oe[0 +: GROUP_W] == {GROUP_W{dir_r[0]}})
    else $error("group0 oe mismatch");

  a_g1_oe: assert property (@(posedge clk) disable iff (!rst_n)
    enable_r |-> group_pins.oe[GROUP_W +: GROUP_W] == {GROUP_W{dir_r[1]}})
    else $error("group1 oe bits mismatch");

  a_g2_oe: assert property (@(posedge clk) disable iff (!rst_n)
    enable_r |-> group_pins.oe[2*GROUP_W +: GROUP_W] == {GROUP_W{dir_r[2]}})
    else $error("group2 oe mismatch");

  // Output groups read back what they drive
  a_g0_readback: assert property (@(posedge clk) disable iff (!rst_n)
    dir_r[0] |-> grp_rd[0 +: GROUP_W] == group_pins.dout[0 +: GROUP_W])
    else $error("group0 readback differs from drive");

  a_g1_readback: assert property (@(posedge clk) disable iff (!rst_n)
    dir_r[1] |-> grp_rd[GROUP_W +: GROUP_W] == group_pins.dout[GROUP_W +: GROUP_W])
    else $error("group1 readback differs from drive");

  a_g2_readback: assert property (@(posedge clk) disable iff (!rst_n)
    dir_r[2] |-> grp_rd[2*GROUP_W +: GROUP_W] == group_pins.dout[2*GROUP_W +: GROUP_W])
    else $error("group2 readback differs from drive");

  // Input groups return pin levels with one cycle of lag while enabled, and hold their last sample while disabled
  a_g1_sample: assert property (@(posedge clk) disable iff (!rst_n)
    (enable_r && !dir_r[1]) ##1 !dir_r[1] |->
      grp_rd[GROUP_W +: GROUP_W] == $past(group_line_in[GROUP_W +: GROUP_W]))
    else $error("group1 input sample wrong");

  a_g0_freeze: assert property (@(posedge clk) disable iff (!rst_n)
    (!enable_r && !dir_r[0]) ##1 !dir_r[0] |-> $stable(grp_rd[0 +: GROUP_W]))
    else $error("group0 sampled while disabled");

  // Register readback in the data phase
  a_rd_enable: assert property (@(posedge clk) disable iff (!rst_n)
    (aph_r.valid && !aph_r.write && aph_r.addr == OFS_ENABLE) |->
      hrdata == {31'h0000_0000, enable_r})
    else $error("enable readback wrong");

  a_rd_dir: assert property (@(posedge clk) disable iff (!rst_n)
    (aph_r.valid && !aph_r.write && aph_r.addr == OFS_DIR) |->
      hrdata == {29'h0000_0000, dir_r})
    else $error("direction readback wrong");

  a_rd_ded_out: assert property (@(posedge clk) disable iff (!rst_n)
    (HAS_DED && aph_r.valid && !aph_r.write && aph_r.addr == OFS_DED_OUT) |->
      hrdata == {16'h0000, ded_out_r})
    else $error("dedicated out readback wrong");

  a_rd_ded_in: assert property (@(posedge clk) disable iff (!rst_n)
    (HAS_DED && aph_r.valid && !aph_r.write && aph_r.addr == OFS_DED_IN) |->
      hrdata == {16'h0000, ded_in_r})
    else $error("dedicated in readback wrong");

  a_rd_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !aph_r.valid |-> hrdata == 32'h0000_0000)
    else $error("read data outside data phase");

  // Dedicated input follows its pins while enabled
  a_ded_in_sample: assert property (@(posedge clk) disable iff (!rst_n)
    (enable_r && HAS_DED) |=> ded_in_r == $past(dedicated_input_line))
    else $error("dedicated in not sampled");

  // Control state changes only on its own write
  a_enable_write: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_act && hit(aph_r, OFS_ENABLE)) |=> enable_r == $past(hwdata[ENABLE_BIT]))
    else $error("enable not stored");

  a_enable_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !(wr_act && hit(aph_r, OFS_ENABLE)) |=> $stable(enable_r))
    else $error("enable changed without write");

  a_dir_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !(wr_act && hit(aph_r, OFS_DIR)) |=> $stable(dir_r))
    else $error("direction changed without write");

  a_ded_out_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !(wr_act && hit(aph_r, OFS_DED_OUT)) |=> $stable(ded_out_r))
    else $error("dedicated out changed without write");

  a_ded_oe_off: assert property (@(posedge clk) disable iff (!rst_n)
    !enable_r |-> dedicated_output_oe == {DED_W{1'b0}})
    else $error("dedicated out driven while disabled");

  // State straight after a reset edge
  a_reset_oe: assert property (@(posedge clk)
    !rst_n |=> (group_pins.oe == '0 && dedicated_output_oe == '0))
    else $error("drivers on after reset");

  a_reset_ded_pins: assert property (@(posedge clk)
    !rst_n |=> dedicated_output_line == DED_OUT_RESET)
    else $error("dedicated out pins not low after reset");

  a_reset_enable: assert property (@(posedge clk)
    !rst_n |=> !enable_r)
    else $error("enable set after reset");

  // Bus answer is always immediate and OKAY
  a_bus_ready: assert property (@(posedge clk) disable iff (!rst_n)
    hreadyout == 1'b1)
    else $error("wait state inserted");

  a_bus_okay: assert property (@(posedge clk) disable iff (!rst_n)
    hresp == HRESP_OKAY)
    else $error("error response given");

endmodule

//--- dio_pin_model.sv
// Outside world of the bidirectional port: pin sources and line resolution
`timescale 1ns/1ns
module dio_pin_model
  import dio_pkg::*;
(
  input  wire logic [N_GROUPS*GROUP_W-1:0] ext_level,
  input  wire dio_pkg::dio_pins_t          pins,
  output logic      [N_GROUPS*GROUP_W-1:0] line_level
);
  // Each line follows the card where it drives, the outside source elsewhere
  always_comb
  begin
    for (int i = 0; i < N_GROUPS*GROUP_W; i++)
    begin
      line_level[i] = pins.oe[i] ? pins.dout[i] : ext_level[i];
    end
  end
endmodule

//--- tb_top.sv
// Self-checking testbench of the digital I/O port controller
`timescale 1ns/1ns
module tb_top;
  import dio_pkg::*;
  logic        clk;
  logic        rst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic [23:0] ext;
  logic [23:0] line_in;
  logic [15:0] ded_in;
  logic [15:0] ded_out;
  logic [15:0] ded_oe;
  dio_pins_t   group_pins;
  int          miscompares;
  int          compares;
  logic [2:0]  dir_tab [4] = '{3'h1, 3'h2, 3'h4, 3'h6};
  logic [23:0] oe_tab [4] = '{24'h0000ff, 24'h00ff00, 24'hff0000, 24'hffff00};
  localparam logic [23:0] LAT = 24'h3c5aa5;

  dio_port_ctrl uut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .group_line_in(line_in), .group_pins(group_pins),
    .dedicated_input_line(ded_in), .dedicated_output_line(ded_out),
    .dedicated_output_oe(ded_oe));
  dio_pin_model pins (.ext_level(ext), .pins(group_pins), .line_level(line_in));

  always #50 clk = ~clk;

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    htrans <= HTRANS_NONSEQ;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask

  task automatic pins_off();
    chk({8'h0, group_pins.oe}, 32'h0);
    chk({16'h0, ded_oe}, 32'h0);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    #500000;
    miscompares++;
    print_verdict();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    clk = 0; rst_n = 0; hsel = 1; haddr = 0; htrans = 0; hwrite = 0;
    hsize = 3'h2; hwdata = 0; ext = 24'h17e481; ded_in = 16'hbeef;
    miscompares = 0; compares = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    pins_off();
    chk({16'h0, ded_out}, 32'h0);
    rd(OFS_ENABLE, 32'h0);
    rd(OFS_GROUP0, 32'h0);
    rd(OFS_DED_IN, 32'h0);
    wr(OFS_GROUP0, {24'h0, LAT[7:0]});
    wr(OFS_GROUP1, {24'h0, LAT[15:8]});
    wr(OFS_DIR, 32'h7);
    wr(OFS_GROUP2, {24'h0, LAT[23:16]});
    pins_off();
    wr(OFS_DIR, 32'h0);
    wr(OFS_ENABLE, 32'h1);
    chk({16'h0, ded_oe}, 32'hffff);
    chk({30'h0, hready, hresp}, 32'h2);
    chk({8'h0, group_pins.oe}, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      wr(OFS_DIR, {29'h0, dir_tab[i]});
      chk({8'h0, group_pins.oe}, {8'h0, oe_tab[i]});
      chk({8'h0, group_pins.dout & oe_tab[i]}, {8'h0, LAT & oe_tab[i]});
      for (int g = 0; g < 3; g++)
        rd(OFS_GROUP0 + 8'(4*g), {24'h0, dir_tab[i][g] ? LAT[8*g+:8] : ext[8*g+:8]});
    end
    rd(OFS_DIR, 32'h6);
    rd(OFS_DED_IN, 32'hbeef);
    wr(OFS_DED_OUT, 32'h1234);
    chk({16'h0, ded_out}, 32'h1234);
    // Disabled: drivers off, input samples frozen
    wr(OFS_ENABLE, 32'h0);
    pins_off();
    ext <= 24'h000042;
    ded_in <= 16'h0f0f;
    rd(OFS_GROUP0, 32'h81);
    rd(OFS_DED_IN, 32'hbeef);
    wr(OFS_ENABLE, 32'h1);
    rd(OFS_GROUP0, 32'h42);
    rd(OFS_DED_IN, 32'h0f0f);
    rd(8'h1c, 32'h0);
    // Reset in mid-run
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    pins_off();
    chk({16'h0, ded_out}, 32'h0);
    rd(OFS_DIR, 32'h0);
    print_verdict();
  end
endmodule
